// file: core/svic_ctrl.sv
// Top of the six-source vectored interrupt controller: special registers,
// event capture, fixed-priority arbitration and the acknowledge sequencer.
// Assumes the CPU core drives one access strobe at a time and marks
// instruction boundaries; the reset generator acts on resetReq.
`timescale 1ns/1ps

// Contract
// R1: Fixed priority, low-voltage highest, wide event B lowest.
// R2: Each maskable source has its own vector.
// R3: Reset causes are unmaskable, all vector to 0000H.
// R4: Low-voltage goes to interrupt or reset by mode.
// R5: Wide events from compare match or capture edge.
// R6: Flag set by source or write, cleared otherwise.
// R7: Request register resets 00H, bits 0, 7 zero.
// R8: Request and mask take bit and byte writes.
// R9: Mask resets FFH, 1 blocks, bits 0, 7 one.
// R10: Software masks pin before port output mode.
// R11: Two-bit selector picks each pin's valid edge.
// R12: Edge register resets 00H, byte writes only.
// R13: Software writes zero to edge bits 0,1,6,7.
// R14: Software masks, reprograms, clears flag, then unmasks.
// R15: Global enable gates acknowledge; status resets 02H.
// R16: Status word byte, bit, enable-all, disable-all access.
// R17: Acknowledge stacks status word, clears global enable.
// R18: Eligible when flag set and mask clear.
// R19: Servicing starts 9 to 19 clocks after request.
// R20: Hold acknowledge while request or mask accessed.
// R21: Synchronise pin inputs before edge detection.
// R22: Hardware set wins over acknowledge clear.
module svic_ctrl
	import svic_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [15:0] sfrAddr,
	input wire logic sfrRd,
	input wire logic sfrWr,
	input wire logic sfrBitOp,
	input wire logic [2:0] sfrBitIdx,
	input wire logic sfrBitVal,
	input wire logic [7:0] sfrWrData,
	output logic [7:0] sfrRdData,
	input wire logic pswWr,
	input wire logic unmaskAll,
	input wire logic maskAll,
	output logic [7:0] programStatusWord,
	output logic [7:0] pswStacked,
	input wire logic cpuBoundary,
	output logic intPending,
	output logic intAck,
	output logic [15:0] intVector,
	input wire logic lowVoltageEvent,
	input wire logic lowVoltageActionSelect,
	input wire logic resetPinReq,
	input wire logic powerOnClearReq,
	input wire logic watchdogOverflowReq,
	output logic resetReq,
	input wire logic pinZeroIn,
	input wire logic pinOneIn,
	input wire logic [7:0] eightTimerCount,
	input wire logic [7:0] eightTimerCompare,
	input wire logic [15:0] wideTimerCount,
	input wire logic [15:0] wideCapCmpA,
	input wire logic [15:0] wideCapCmpB,
	input wire logic wideCaptureModeA,
	input wire logic wideCaptureModeB,
	input wire logic capturePinA,
	input wire logic capturePinB
);

	logic [7:0] requestFlags_r;
	logic [7:0] requestFlags_nxt;
	logic [7:0] maskFlags_r;
	logic [7:0] maskFlags_nxt;
	logic [7:0] pinEdgeSelect_r;
	logic [7:0] pinEdgeSelect_nxt;
	logic [7:0] psw_r;
	logic [7:0] psw_nxt;
	logic [7:0] pswStacked_r;
	logic [7:0] pswStacked_nxt;
	logic [7:0] rdData_r;
	logic [7:0] rdData_nxt;
	logic [2:0] matchPrev_r;
	logic [2:0] matchPrev_nxt;
	logic [2:0] matchNow;
	logic holdAcc_r;
	logic holdAcc_nxt;
	svic_state_t state_r;
	svic_state_t state_nxt;
	logic [4:0] waitCnt_r;
	logic [4:0] waitCnt_nxt;
	logic intAck_r;
	logic intAck_nxt;
	logic [15:0] intVector_r;
	logic [15:0] intVector_nxt;
	logic resetReq_r;
	logic resetReq_nxt;
	logic [1:0] chanSel [EDGE_CHANNELS];
	logic chanRaw [EDGE_CHANNELS];
	logic chanPulse [EDGE_CHANNELS];
	logic [7:0] hwSet;
	logic [7:0] eligible;
	logic [2:0] winIdx;
	logic globalAccept;
	logic accessHold;
	logic ackFire;
	logic wrReq;
	logic wrMask;
	logic wrEdge;
	logic accReqMask;

	// Address decode of the special register strobes
	assign wrReq = sfrWr & (sfrAddr == ADDR_REQ);
	assign wrMask = sfrWr & (sfrAddr == ADDR_MASK);
	assign wrEdge = sfrWr & ~sfrBitOp & (sfrAddr == ADDR_EDGE); // [R12]
	assign accReqMask = (sfrRd | sfrWr) & ((sfrAddr == ADDR_REQ) | (sfrAddr == ADDR_MASK));

	// Edge channels: two interrupt pins, then the two capture pins
	assign chanSel[0] = pinEdgeSelect_r[PIN0_SEL_LO +: 2]; // [R11]
	assign chanSel[1] = pinEdgeSelect_r[PIN1_SEL_LO +: 2]; // [R11]
	assign chanSel[2] = EDGE_RISE;
	assign chanSel[3] = EDGE_RISE;
	assign chanRaw[0] = pinZeroIn;
	assign chanRaw[1] = pinOneIn;
	assign chanRaw[2] = capturePinB;
	assign chanRaw[3] = capturePinA;

	// One synchronised edge detector per channel
	generate
		for (genvar k = 0; k < EDGE_CHANNELS; k++) begin : gEdge
			svic_edge_if edgeBus ();
			assign edgeBus.edgeSel = chanSel[k];
			assign edgeBus.pinRaw = chanRaw[k];
			assign chanPulse[k] = edgeBus.edgePulse;
			svic_edge_det uDet (
				.core_clk(core_clk),
				.srst(srst),
				.edgeBus(edgeBus.det)
			);
		end
	endgenerate

	// Compare matches, each counted once on its first equal cycle
	always_comb begin
		matchNow[0] = (eightTimerCount == eightTimerCompare);
		matchNow[1] = (wideTimerCount == wideCapCmpA) & ~wideCaptureModeA; // [R5]
		matchNow[2] = (wideTimerCount == wideCapCmpB) & ~wideCaptureModeB; // [R5]
		matchPrev_nxt = matchNow;
	end

	// Hardware request set per source position
	always_comb begin
		hwSet = 8'h00;
		hwSet[SRC_LVI] = lowVoltageEvent & ~lowVoltageActionSelect; // [R4]
		hwSet[SRC_PIN0] = chanPulse[0];
		hwSet[SRC_PIN1] = chanPulse[1];
		hwSet[SRC_TMR8] = matchNow[0] & ~matchPrev_r[0];
		hwSet[SRC_WIDE_A] = (matchNow[1] & ~matchPrev_r[1]) | (wideCaptureModeA & chanPulse[2]); // [R5]
		hwSet[SRC_WIDE_B] = (matchNow[2] & ~matchPrev_r[2]) | (wideCaptureModeB & chanPulse[3]); // [R5]
	end

	// Eligibility and fixed-priority winner, lowest position wins
	always_comb begin
		eligible = requestFlags_r & ~maskFlags_r & SRC_BITS; // [R18] [R9]
		winIdx = 3'h0;
		for (int i = SRC_WIDE_B; i >= SRC_LVI; i--) begin
			if (eligible[i]) begin
				winIdx = 3'(i); // [R1]
			end
		end
	end

	assign globalAccept = psw_r[PSW_IE_BIT];
	assign accessHold = accReqMask | holdAcc_r; // [R20]
	assign intPending = (|eligible) & globalAccept; // [R15] [R18]

	// Acknowledge sequencer with latency window
	always_comb begin
		state_nxt = state_r;
		waitCnt_nxt = waitCnt_r;
		ackFire = 1'b0;
		case (state_r)
			ST_IDLE: begin
				if (intPending) begin
					state_nxt = ST_WAIT;
					waitCnt_nxt = 5'h01;
				end
			end
			ST_WAIT: begin
				if (!intPending) begin
					state_nxt = ST_IDLE;
				end else if (!accessHold && ((waitCnt_r >= ACK_MIN_FIRE && cpuBoundary) ||
						waitCnt_r >= ACK_MAX_FIRE)) begin
					ackFire = 1'b1; // [R19] [R15]
					state_nxt = ST_ACK;
				end else if (waitCnt_r < ACK_MAX_FIRE) begin
					waitCnt_nxt = waitCnt_r + 5'h01;
				end
			end
			ST_ACK: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Request flags: software first, then acknowledge clear, hardware set last
	always_comb begin
		requestFlags_nxt = requestFlags_r;
		if (wrReq) begin
			if (sfrBitOp) begin
				requestFlags_nxt[sfrBitIdx] = sfrBitVal; // [R8]
			end else begin
				requestFlags_nxt = sfrWrData; // [R8] [R6]
			end
		end
		if (ackFire) begin
			requestFlags_nxt[winIdx] = 1'b0; // [R6]
		end
		requestFlags_nxt = (requestFlags_nxt | hwSet) & SRC_BITS; // [R22] [R6] [R7]
	end

	// Mask flags with bits 0 and 7 held at one
	always_comb begin
		maskFlags_nxt = maskFlags_r;
		if (wrMask) begin
			if (sfrBitOp) begin
				maskFlags_nxt[sfrBitIdx] = sfrBitVal; // [R8]
			end else begin
				maskFlags_nxt = sfrWrData; // [R8]
			end
		end
		maskFlags_nxt = maskFlags_nxt | MASK_FIXED_ONES; // [R9]
		pinEdgeSelect_nxt = wrEdge ? (sfrWrData & EDGE_BITS) : pinEdgeSelect_r; // [R12]
		holdAcc_nxt = accReqMask; // [R20]
	end

	// Status word: byte or bit write, enable-all, disable-all, then acknowledge
	always_comb begin
		psw_nxt = psw_r;
		pswStacked_nxt = pswStacked_r;
		if (pswWr) begin
			if (sfrBitOp) begin
				psw_nxt[sfrBitIdx] = sfrBitVal; // [R16]
			end else begin
				psw_nxt = sfrWrData; // [R16]
			end
		end
		if (unmaskAll) begin
			psw_nxt[PSW_IE_BIT] = 1'b1; // [R16]
		end
		if (maskAll) begin
			psw_nxt[PSW_IE_BIT] = 1'b0; // [R16]
		end
		if (ackFire) begin
			pswStacked_nxt = psw_r; // [R17]
			psw_nxt[PSW_IE_BIT] = 1'b0; // [R17]
		end
	end

	// Vector, acknowledge pulse and reset request
	always_comb begin
		resetReq_nxt = resetPinReq | powerOnClearReq | watchdogOverflowReq |
			(lowVoltageEvent & lowVoltageActionSelect); // [R3] [R4]
		intAck_nxt = ackFire;
		intVector_nxt = intVector_r;
		if (resetReq_nxt) begin
			intVector_nxt = VEC_RESET; // [R3]
		end else if (ackFire) begin
			intVector_nxt = VEC_TABLE[winIdx]; // [R2]
		end
	end

	// Read data, unmapped addresses answer zero
	always_comb begin
		rdData_nxt = rdData_r;
		if (sfrRd) begin
			case (sfrAddr)
				ADDR_REQ: rdData_nxt = requestFlags_r; // [R7]
				ADDR_MASK: rdData_nxt = maskFlags_r; // [R9]
				ADDR_EDGE: rdData_nxt = pinEdgeSelect_r;
				default: rdData_nxt = 8'h00;
			endcase
		end
	end

	// Register all state
	always_ff @(posedge core_clk) begin
		if (srst) begin
			requestFlags_r <= RST_REQ; // [R7]
			maskFlags_r <= RST_MASK; // [R9]
			pinEdgeSelect_r <= RST_EDGE; // [R12]
			psw_r <= RST_PSW; // [R15]
			pswStacked_r <= RST_PSW;
			rdData_r <= 8'h00;
			matchPrev_r <= 3'h0;
			holdAcc_r <= 1'b0;
			state_r <= ST_IDLE;
			waitCnt_r <= 5'h00;
			intAck_r <= 1'b0;
			intVector_r <= VEC_RESET;
			resetReq_r <= 1'b0;
		end else begin
			requestFlags_r <= requestFlags_nxt;
			maskFlags_r <= maskFlags_nxt;
			pinEdgeSelect_r <= pinEdgeSelect_nxt;
			psw_r <= psw_nxt;
			pswStacked_r <= pswStacked_nxt;
			rdData_r <= rdData_nxt;
			matchPrev_r <= matchPrev_nxt;
			holdAcc_r <= holdAcc_nxt;
			state_r <= state_nxt;
			waitCnt_r <= waitCnt_nxt;
			intAck_r <= intAck_nxt;
			intVector_r <= intVector_nxt;
			resetReq_r <= resetReq_nxt;
		end
	end

	// Outputs
	assign sfrRdData = rdData_r;
	assign programStatusWord = psw_r;
	assign pswStacked = pswStacked_r;
	assign intAck = intAck_r;
	assign intVector = intVector_r;
	assign resetReq = resetReq_r;

endmodule : svic_ctrl

// file: core/svic_pkg.sv
// Constants, encodings and states of the six-source vectored interrupt controller.
// Assumes one 40 MHz core clock and a CPU core that drives the special register strobes.
package svic_pkg;

	// Special register addresses
	localparam logic [15:0] ADDR_REQ = 16'hFFE0;
	localparam logic [15:0] ADDR_MASK = 16'hFFE4;
	localparam logic [15:0] ADDR_EDGE = 16'hFFEC;

	// Values after reset
	localparam logic [7:0] RST_REQ = 8'h00;
	localparam logic [7:0] RST_MASK = 8'hFF;
	localparam logic [7:0] RST_EDGE = 8'h00;
	localparam logic [7:0] RST_PSW = 8'h02;

	// Field layouts
	localparam logic [7:0] SRC_BITS = 8'h7E;
	localparam logic [7:0] MASK_FIXED_ONES = 8'h81;
	localparam logic [7:0] EDGE_BITS = 8'h3C;
	localparam int PIN0_SEL_LO = 2;
	localparam int PIN1_SEL_LO = 4;
	localparam logic [2:0] PSW_IE_BIT = 3'h7;

	// Source positions in the request and mask registers, 1 is the highest priority
	localparam int SRC_LVI = 1;
	localparam int SRC_PIN0 = 2;
	localparam int SRC_PIN1 = 3;
	localparam int SRC_TMR8 = 4;
	localparam int SRC_WIDE_A = 5;
	localparam int SRC_WIDE_B = 6;

	// Vector table addresses, indexed by source position
	localparam logic [15:0] VEC_RESET = 16'h0000;
	localparam logic [15:0] VEC_TABLE [0:7] = '{16'h0000, 16'h0006, 16'h0008, 16'h000A,
		16'h000C, 16'h000E, 16'h0010, 16'h0000};

	// Valid edge selector codes
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BAN = 2'h2;
	localparam logic [1:0] EDGE_BOTH = 2'h3;

	// Edge detector channels
	localparam int EDGE_CHANNELS = 4;

	// Request to acknowledge latency in core clocks
	localparam logic [4:0] ACK_MIN_CYCLES = 5'h09;
	localparam logic [4:0] ACK_MAX_CYCLES = 5'h13;
	localparam logic [4:0] ACK_MIN_FIRE = ACK_MIN_CYCLES - 5'h01;
	localparam logic [4:0] ACK_MAX_FIRE = ACK_MAX_CYCLES - 5'h01;

	// Acknowledge sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_ACK = 3'h4
	} svic_state_t;

endpackage : svic_pkg

// file: core/svic_edge_if.sv
// Interface between the controller and one edge detector channel.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface svic_edge_if;
	logic [1:0] edgeSel;
	logic pinRaw;
	logic edgePulse;

	modport ctrl (output edgeSel, output pinRaw, input edgePulse);
	modport det (input edgeSel, input pinRaw, output edgePulse);
endinterface : svic_edge_if

// file: core/svic_edge_det.sv
// Synchroniser and selectable edge detector for one pin.
// Assumes the pin may change at any time relative to the core clock.
`timescale 1ns/1ps
module svic_edge_det
	import svic_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	svic_edge_if.det edgeBus
);

	logic syncA_r;
	logic syncB_r;
	logic prev_r;
	logic syncA_nxt;
	logic syncB_nxt;
	logic prev_nxt;

	// Two-stage synchroniser, then one stage of history
	always_comb begin
		syncA_nxt = edgeBus.pinRaw; // [R21]
		syncB_nxt = syncA_r;
		prev_nxt = syncB_r;
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			syncA_r <= 1'b0;
			syncB_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			syncA_r <= syncA_nxt;
			syncB_r <= syncB_nxt;
			prev_r <= prev_nxt;
		end
	end

	// Qualify the edge by the selector; the banned code detects nothing
	always_comb begin
		case (edgeBus.edgeSel)
			EDGE_FALL: edgeBus.edgePulse = prev_r & ~syncB_r; // [R11]
			EDGE_RISE: edgeBus.edgePulse = ~prev_r & syncB_r; // [R11]
			EDGE_BOTH: edgeBus.edgePulse = prev_r ^ syncB_r; // [R11]
			default: edgeBus.edgePulse = 1'b0;
		endcase
	end

endmodule : svic_edge_det

// file: dv/svic_ctrl_properties.sv
// Concurrent checks on the interrupt controller top ports.
// Assumes one core clock and the synchronous active-high reset srst.
`timescale 1ns/1ps
module svic_ctrl_properties
	import svic_pkg::*;
(
	input wire logic core_clk,
	input wire logic srst,
	input wire logic [15:0] sfrAddr,
	input wire logic sfrRd,
	input wire logic [7:0] sfrRdData,
	input wire logic unmaskAll,
	input wire logic maskAll,
	input wire logic [7:0] programStatusWord,
	input wire logic [7:0] pswStacked,
	input wire logic intPending,
	input wire logic intAck,
	input wire logic [15:0] intVector,
	input wire logic lowVoltageEvent,
	input wire logic lowVoltageActionSelect,
	input wire logic resetPinReq,
	input wire logic powerOnClearReq,
	input wire logic watchdogOverflowReq,
	input wire logic resetReq
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	// Acknowledge sequencing
	ack_one_cycle_a: assert property (intAck |=> !intAck) else $error("ack longer than one cycle");
	ack_clears_ie_a: assert property (intAck |-> !programStatusWord[7] && pswStacked[7])
		else $error("ack did not stack and clear enable");
	ack_needs_ie_a: assert property (intAck |-> $past(programStatusWord[7])) else $error("ack with enable off");
	pend_needs_ie_a: assert property (intPending |-> programStatusWord[7]) else $error("pending with enable off");
	ack_vector_a: assert property (intAck |-> intVector inside {16'h0006, 16'h0008, 16'h000A,
		16'h000C, 16'h000E, 16'h0010}) else $error("ack vector outside table");
	ack_min_wait_a: assert property ($rose(intPending) |-> !intAck [*8]) else $error("ack too early");
	// Reset request routing
	reset_route_a: assert property (!$past(srst) |-> resetReq == $past(resetPinReq || powerOnClearReq
		|| watchdogOverflowReq || (lowVoltageEvent && lowVoltageActionSelect))) else $error("reset route wrong");
	reset_vector_a: assert property (resetReq |-> intVector == VEC_RESET) else $error("reset vector wrong");
	// Fixed bits seen on reads
	mask_read_a: assert property (sfrRd && sfrAddr == ADDR_MASK |=> sfrRdData[0] && sfrRdData[7])
		else $error("mask fixed bits wrong");
	req_read_a: assert property (sfrRd && sfrAddr == ADDR_REQ |=> (sfrRdData & ~SRC_BITS) == 8'h00)
		else $error("request fixed bits wrong");
	edge_read_a: assert property (sfrRd && sfrAddr == ADDR_EDGE |=> (sfrRdData & ~EDGE_BITS) == 8'h00)
		else $error("edge fixed bits wrong");
	// Dedicated enable commands
	ie_set_a: assert property (unmaskAll && !maskAll |=> programStatusWord[7] || intAck)
		else $error("enable-all failed");
	ie_clr_a: assert property (maskAll && !unmaskAll |=> !programStatusWord[7]) else $error("disable-all failed");
	cover property (intAck && intVector == 16'h0010);
	cover property (resetReq);
	cover property ($rose(intPending));
endmodule : svic_ctrl_properties

bind svic_ctrl svic_ctrl_properties i_props (.core_clk(core_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrRd(sfrRd),
	.sfrRdData(sfrRdData), .unmaskAll(unmaskAll), .maskAll(maskAll), .programStatusWord(programStatusWord),
	.pswStacked(pswStacked), .intPending(intPending), .intAck(intAck), .intVector(intVector),
	.lowVoltageEvent(lowVoltageEvent), .lowVoltageActionSelect(lowVoltageActionSelect), .resetPinReq(resetPinReq),
	.powerOnClearReq(powerOnClearReq), .watchdogOverflowReq(watchdogOverflowReq), .resetReq(resetReq));

// file: dv/svic_cpu_model.sv
// CPU core model: offers instruction boundaries and counts taken vectors.
// Assumes the controller runs on the same core clock.
`timescale 1ns/1ps
module svic_cpu_model (
	input wire logic core_clk,
	input wire logic srst,
	input wire logic slow,
	input wire logic intAck,
	output logic cpuBoundary,
	output logic [7:0] ackCount
);
	logic [1:0] phase_r;
	// Boundary on every fourth clock, never while slow
	assign cpuBoundary = !slow && phase_r == 2'h3;
	// Phase and acknowledge counting
	always_ff @(posedge core_clk) begin
		if (srst) begin
			phase_r <= 2'h0;
			ackCount <= 8'h00;
		end else begin
			phase_r <= phase_r + 2'h1;
			ackCount <= ackCount + {7'h00, intAck};
		end
	end
endmodule : svic_cpu_model

// file: dv/testbench.sv
// Self-checking bench for the interrupt controller top.
// Assumes a 40 MHz core clock and the CPU core model beside the controller.
`timescale 1ns/1ps
module testbench
	import svic_pkg::*;
;
	typedef struct packed {logic [7:0] req; logic [7:0] mask; logic [15:0] vec; logic [7:0] left;} svic_row_t;
	logic core_clk, srst, sfrRd, sfrWr, sfrBitOp, sfrBitVal, pswWr, unmaskAll, maskAll, slow;
	logic cpuBoundary, intPending, intAck, resetReq, lowVoltageEvent, lvSel, pinIn, capPin, capModeA, capModeB;
	logic [2:0] sfrBitIdx, rc;
	logic [7:0] sfrWrData, sfrRdData, programStatusWord, pswStacked, tmr8, ackCount, d, a0;
	logic [15:0] sfrAddr, intVector, wideCount;
	int n_fail, samples_checked, n;
	svic_row_t rows [7] = '{'{8'h7E, 8'h81, 16'h0006, 8'h7C}, '{8'h7C, 8'h81, 16'h0008, 8'h78},
		'{8'h78, 8'h81, 16'h000A, 8'h70}, '{8'h70, 8'h81, 16'h000C, 8'h60}, '{8'h60, 8'h81, 16'h000E, 8'h40},
		'{8'h40, 8'h81, 16'h0010, 8'h00}, '{8'h7E, 8'h87, 16'h000A, 8'h76}};
	svic_ctrl i_dut (.core_clk(core_clk), .srst(srst), .sfrAddr(sfrAddr), .sfrRd(sfrRd), .sfrWr(sfrWr),
		.sfrBitOp(sfrBitOp), .sfrBitIdx(sfrBitIdx), .sfrBitVal(sfrBitVal), .sfrWrData(sfrWrData),
		.sfrRdData(sfrRdData), .pswWr(pswWr), .unmaskAll(unmaskAll), .maskAll(maskAll),
		.programStatusWord(programStatusWord), .pswStacked(pswStacked), .cpuBoundary(cpuBoundary),
		.intPending(intPending), .intAck(intAck), .intVector(intVector), .lowVoltageEvent(lowVoltageEvent),
		.lowVoltageActionSelect(lvSel), .resetPinReq(rc[0]), .powerOnClearReq(rc[1]), .watchdogOverflowReq(rc[2]),
		.resetReq(resetReq), .pinZeroIn(pinIn), .pinOneIn(pinIn), .eightTimerCount(tmr8),
		.eightTimerCompare(8'hAA), .wideTimerCount(wideCount), .wideCapCmpA(16'h1234), .wideCapCmpB(16'h5678),
		.wideCaptureModeA(capModeA), .wideCaptureModeB(capModeB), .capturePinA(capPin), .capturePinB(capPin));
	svic_cpu_model i_cpu (.core_clk(core_clk), .srst(srst), .slow(slow), .intAck(intAck),
		.cpuBoundary(cpuBoundary), .ackCount(ackCount));
	// Core clock, 25 ns period
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	// Step to just after the next rising edge
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask : tick
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] v, input logic b, input logic [2:0] i);
		sfrAddr = a;
		sfrWrData = v;
		sfrBitOp = b;
		sfrBitIdx = i;
		sfrBitVal = v[0];
		sfrWr = 1'b1;
		tick();
		sfrWr = 1'b0;
		tick();
	endtask : wr
	task automatic rd(input logic [15:0] a);
		sfrAddr = a;
		sfrRd = 1'b1;
		tick();
		d = sfrRdData;
		sfrRd = 1'b0;
		tick();
	endtask : rd
	task automatic pw(input logic b, input logic [7:0] v);
		sfrBitOp = b;
		sfrBitIdx = 3'h7;
		sfrBitVal = 1'b1;
		sfrWrData = v;
		pswWr = 1'b1;
		tick();
		pswWr = 1'b0;
		tick();
	endtask : pw
	task automatic ei();
		unmaskAll = 1'b1;
		tick();
		unmaskAll = 1'b0;
	endtask : ei
	task automatic wack();
		n = 0;
		while (intAck !== 1'b1 && n < 40) begin
			tick();
			n++;
		end
	endtask : wack
	task automatic conclude();
		$display("checked %0d failed %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	// Watchdog against a hung run
	initial begin
		repeat (20000) @(posedge core_clk);
		n_fail++;
		conclude();
	end
	// Main sequence
	initial begin
		srst = 1'b1;
		{sfrRd, sfrWr, sfrBitOp, sfrBitVal, pswWr, unmaskAll, maskAll, slow, lowVoltageEvent, lvSel, pinIn} = '0;
		{capPin, sfrBitIdx, rc, sfrWrData, tmr8, sfrAddr, wideCount} = '0;
		{capModeA, capModeB} = 2'b01;
		n_fail = 0;
		samples_checked = 0;
		repeat (4) tick();
		srst = 1'b0;
		rd(ADDR_REQ);
		chk("req reset", d, 8'h00);
		rd(ADDR_MASK);
		chk("mask reset", d, 8'hFF);
		rd(ADDR_EDGE);
		chk("edge reset", d, 8'h00);
		rd(16'hFFF0);
		chk("unmapped", d, 8'h00);
		chk("psw reset", programStatusWord, 8'h02);
		$display("reset test done");
		// Bit and byte writes
		wr(ADDR_MASK, 8'h00, 1'b0, 3'h0);
		rd(ADDR_MASK);
		chk("mask byte", d, 8'h81);
		wr(ADDR_MASK, 8'h01, 1'b1, 3'h3);
		rd(ADDR_MASK);
		chk("mask bit", d, 8'h89);
		wr(ADDR_REQ, 8'h01, 1'b1, 3'h4);
		rd(ADDR_REQ);
		chk("req bit", d, 8'h10);
		wr(ADDR_EDGE, 8'h01, 1'b1, 3'h2);
		rd(ADDR_EDGE);
		chk("edge bit ignored", d, 8'h00);
		wr(ADDR_MASK, 8'hFF, 1'b0, 3'h0);
		wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
		pw(1'b1, 8'h00);
		chk("psw bit", programStatusWord, 8'h82);
		pw(1'b0, 8'h00);
		chk("psw byte", programStatusWord, 8'h00);
		ei();
		tick();
		chk("enable all", programStatusWord[7], 1'b1);
		maskAll = 1'b1;
		tick();
		maskAll = 1'b0;
		tick();
		chk("disable all", programStatusWord[7], 1'b0);
		$display("access test done");
		// Priority table rows
		foreach (rows[k]) begin
			wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
			wr(ADDR_MASK, rows[k].mask, 1'b0, 3'h0);
			wr(ADDR_REQ, rows[k].req, 1'b0, 3'h0);
			ei();
			wack();
			chk("latency", n >= 9 && n <= 19, 1'b1);
			chk("vector", intVector, rows[k].vec);
			chk("ie after ack", programStatusWord[7], 1'b0);
			chk("stacked", pswStacked, 8'h80);
			rd(ADDR_REQ);
			chk("flag cleared", d, rows[k].left);
		end
		$display("priority test done");
		// Enable gating, then latency with no boundary
		wr(ADDR_MASK, 8'hFD, 1'b0, 3'h0);
		wr(ADDR_REQ, 8'h02, 1'b0, 3'h0);
		a0 = ackCount;
		repeat (30) tick();
		chk("no ack ie off", ackCount, a0);
		chk("no pending", intPending, 1'b0);
		slow = 1'b1;
		ei();
		wack();
		chk("slow latency", n == 19, 1'b1);
		slow = 1'b0;
		// Held while request register is being read
		wr(ADDR_REQ, 8'h02, 1'b0, 3'h0);
		ei();
		a0 = ackCount;
		repeat (15) rd(ADDR_REQ);
		chk("held", ackCount, a0);
		wack();
		chk("released", intAck, 1'b1);
		$display("gating test done");
		// Pin edge codes, masked while reprogrammed
		wr(ADDR_MASK, 8'hFF, 1'b0, 3'h0);
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_EDGE, {2'h0, c[1:0], c[1:0], 2'h0}, 1'b0, 3'h0);
			wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
			pinIn = 1'b1;
			repeat (6) tick();
			rd(ADDR_REQ);
			chk("rise", d, (c == 1 || c == 3) ? 8'h0C : 8'h00);
			wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
			pinIn = 1'b0;
			repeat (6) tick();
			rd(ADDR_REQ);
			chk("fall", d, (c == 0 || c == 3) ? 8'h0C : 8'h00);
		end
		// Timer match and capture events
		wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
		tmr8 = 8'hAA;
		wideCount = 16'h1234;
		capPin = 1'b1;
		repeat (6) tick();
		rd(ADDR_REQ);
		chk("timers", d, 8'h70);
		wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
		wideCount = 16'h5678;
		repeat (4) tick();
		rd(ADDR_REQ);
		chk("capture ignores match", d, 8'h00);
		// Modes swapped: event A captures, event B compares
		capPin = 1'b0;
		wideCount = 16'h0000;
		{capModeA, capModeB} = 2'b10;
		repeat (4) tick();
		wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
		wideCount = 16'h5678;
		capPin = 1'b1;
		repeat (6) tick();
		rd(ADDR_REQ);
		chk("modes swapped", d, 8'h60);
		wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
		wideCount = 16'h1234;
		repeat (4) tick();
		rd(ADDR_REQ);
		chk("capture a ignores match", d, 8'h00);
		$display("event test done");
		// Low-voltage routing and reset causes
		lowVoltageEvent = 1'b1;
		tick();
		lowVoltageEvent = 1'b0;
		chk("lv no reset", resetReq, 1'b0);
		rd(ADDR_REQ);
		chk("lv flag", d, 8'h02);
		wr(ADDR_REQ, 8'h00, 1'b0, 3'h0);
		lvSel = 1'b1;
		lowVoltageEvent = 1'b1;
		tick();
		lowVoltageEvent = 1'b0;
		chk("lv reset", resetReq, 1'b1);
		chk("reset vector", intVector, VEC_RESET);
		rd(ADDR_REQ);
		chk("lv no flag", d, 8'h00);
		for (int k = 0; k < 3; k++) begin
			rc = 3'h1 << k;
			tick();
			chk("cause", resetReq, 1'b1);
			rc = 3'h0;
			tick();
			chk("cause gone", resetReq, 1'b0);
		end
		// Second reset in mid-run
		wr(ADDR_MASK, 8'h00, 1'b0, 3'h0);
		srst = 1'b1;
		repeat (2) tick();
		srst = 1'b0;
		rd(ADDR_MASK);
		chk("mask rereset", d, 8'hFF);
		$display("reset cause test done");
		conclude();
	end
endmodule : testbench
